// ===== core/dcir_defines.svh
// constants for the dual core interrupt router
`ifndef DCIR_DEFINES_SVH
`define DCIR_DEFINES_SVH
`define DCIR_NUM_SRC      69
`define DCIR_SRC_LIMIT    7'h45
`define DCIR_PERIPH_MASK  32'hdffe_773f
`define DCIR_PERIPH_COUNT 26
`define DCIR_NMI_LINE     5'h0e
`define DCIR_NMI_BIT      32'h0000_4000
`define DCIR_ONE_HOT      32'h0000_0001
`define DCIR_ROUTE_RST    5'h06
`define DCIR_RGN_PRI      3'h0
`define DCIR_RGN_SEC      3'h1
`define DCIR_RGN_MISC     3'h2
`define DCIR_IDX_LVL0     7'h00
`define DCIR_IDX_LVL1     7'h01
`define DCIR_IDX_LVL2     7'h02
`define DCIR_IDX_EVT_STAT 7'h04
`define DCIR_IDX_EVT_CLR  7'h05
`define DCIR_IDX_EVT_EN   7'h06
`define DCIR_EVT_W        2
`endif

// ===== core/dcir_pkg.sv
// types shared by the dual core interrupt router
package dcir_pkg;
    typedef logic [4:0] dcir_line_t;
    typedef struct packed {
        logic        we;
        logic [3:0]  sel;
        logic [2:0]  rgn;
        logic [6:0]  idx;
        logic [31:0] dat;
    } dcir_wb_req_t;
endpackage

// ===== core/dcir_router.sv
// interrupt routing matrix for two cores with wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "dcir_defines.svh"
module dcir_router (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [68:0] src_irq_i,
    input  wire logic        primary_nmi_mask_i,
    input  wire logic        secondary_nmi_mask_i,
    output logic      [31:0] primary_core_irq_o,
    output logic      [31:0] secondary_core_irq_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////
    // bus decode
    dcir_pkg::dcir_wb_req_t req;
    dcir_pkg::dcir_line_t   route_p_r [`DCIR_NUM_SRC];
    dcir_pkg::dcir_line_t   route_s_r [`DCIR_NUM_SRC];
    logic [68:0] level_r;
    logic [`DCIR_EVT_W-1:0] evt_r;
    logic [`DCIR_EVT_W-1:0] evt_en_r;
    logic [`DCIR_EVT_W-1:0] evt_nxt;
    logic        ack_r;
    logic [31:0] rdat_r;

    // ack is held off for one cycle after it is given, so one request
    // is never taken twice
    assign req = '{we: wb_we_i, sel: wb_sel_i, rgn: wb_adr_i[11:9],
                   idx: wb_adr_i[8:2], dat: wb_dat_i};
    wire take   = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wr_b0  = take & req.we & req.sel[0];
    wire idx_ok = req.idx < `DCIR_SRC_LIMIT;
    wire wr_pri = wr_b0 & (req.rgn == `DCIR_RGN_PRI) & idx_ok;
    wire wr_sec = wr_b0 & (req.rgn == `DCIR_RGN_SEC) & idx_ok;
    wire is_misc = req.rgn == `DCIR_RGN_MISC;
    wire wr_clr = wr_b0 & is_misc & (req.idx == `DCIR_IDX_EVT_CLR);
    wire wr_en  = wr_b0 & is_misc & (req.idx == `DCIR_IDX_EVT_EN);
    wire [31:0] pmask = `DCIR_PERIPH_MASK;

    ////////////////////////////////////////////////////////////////////
    // route storage and matrix, one entry per source
    logic [31:0] acc_p [`DCIR_NUM_SRC+1];
    logic [31:0] acc_s [`DCIR_NUM_SRC+1];
    logic [68:0] intl_s;
    logic [68:0] intl_p;
    assign acc_p[0] = '0;
    assign acc_s[0] = '0;
    genvar s;
    generate
        for (s = 0; s < `DCIR_NUM_SRC; s++) begin : g_src
            // separate field per core and source, 5 bits wide
            always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    route_p_r[s] <= `DCIR_ROUTE_RST;
                    route_s_r[s] <= `DCIR_ROUTE_RST;
                end else begin
                    if (wr_pri && req.idx == 7'(s)) begin
                        route_p_r[s] <= req.dat[4:0];
                    end
                    if (wr_sec && req.idx == 7'(s)) begin
                        route_s_r[s] <= req.dat[4:0];
                    end
                end
            end
            // decode the line number and OR it into the chain
            assign acc_p[s+1] = acc_p[s] | ({32{src_irq_i[s]}} &
                                (`DCIR_ONE_HOT << route_p_r[s]));
            assign acc_s[s+1] = acc_s[s] | ({32{src_irq_i[s]}} &
                                (`DCIR_ONE_HOT << route_s_r[s]));
            assign intl_s[s]  = ~pmask[route_s_r[s]];
            // high while the primary route of this source is internal
            assign intl_p[s]  = ~pmask[route_p_r[s]];
        end
    endgenerate

    // internal line numbers land on bits that the mask removes, so every
    // internal value behaves the same: the source is simply dropped
    wire [31:0] raw_p = acc_p[`DCIR_NUM_SRC] & `DCIR_PERIPH_MASK;
    wire [31:0] raw_s = acc_s[`DCIR_NUM_SRC] & `DCIR_PERIPH_MASK;
    wire [31:0] keep_p = primary_nmi_mask_i ? ~`DCIR_NMI_BIT : '1;
    wire [31:0] keep_s = secondary_nmi_mask_i ? ~`DCIR_NMI_BIT : '1;
    wire [`DCIR_EVT_W-1:0] evt_set = {raw_s[`DCIR_NMI_LINE] & secondary_nmi_mask_i,
                                      raw_p[`DCIR_NMI_LINE] & primary_nmi_mask_i};
    wire [`DCIR_EVT_W-1:0] evt_clr = wr_clr ? req.dat[`DCIR_EVT_W-1:0] : '0;
    // set beats clear so a block seen in the clearing cycle is kept
    assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

    ////////////////////////////////////////////////////////////////////
    // read mux
    wire [31:0] rd_misc =
        (req.idx == `DCIR_IDX_LVL0)     ? level_r[31:0] :
        (req.idx == `DCIR_IDX_LVL1)     ? level_r[63:32] :
        (req.idx == `DCIR_IDX_LVL2)     ? {27'h0, level_r[68:64]} :
        (req.idx == `DCIR_IDX_EVT_STAT) ? {30'h0, evt_r} :
        (req.idx == `DCIR_IDX_EVT_EN)   ? {30'h0, evt_en_r} : '0;
    wire [4:0] rd_p = idx_ok ? route_p_r[req.idx] : 5'h00;
    wire [4:0] rd_s = idx_ok ? route_s_r[req.idx] : 5'h00;
    wire [31:0] rd_mux =
        (req.rgn == `DCIR_RGN_PRI) ? {27'h0, rd_p} :
        (req.rgn == `DCIR_RGN_SEC) ? {27'h0, rd_s} :
        is_misc ? rd_misc : '0;

    ////////////////////////////////////////////////////////////////////
    // registered outputs, one cycle from source to core line
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            primary_core_irq_o   <= '0;
            secondary_core_irq_o <= '0;
            level_r              <= '0;
        end else begin
            primary_core_irq_o   <= raw_p & keep_p;
            secondary_core_irq_o <= raw_s & keep_s;
            level_r              <= src_irq_i;
        end
    end

    // bus answer and event flags
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_r    <= 1'b0;
            rdat_r   <= '0;
            evt_r    <= '0;
            evt_en_r <= '0;
            irq_o    <= 1'b0;
        end else begin
            ack_r    <= take;
            rdat_r   <= take ? rd_mux : '0;
            evt_r    <= evt_nxt;
            evt_en_r <= wr_en ? req.dat[`DCIR_EVT_W-1:0] : evt_en_r;
            irq_o    <= |(evt_nxt & evt_en_r);
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence bus_ans_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
        else $error("bus ack not one cycle after request");
    line_count_a: assert property
        ($countones(pmask) == `DCIR_PERIPH_COUNT)
        else $error("peripheral line count wrong");
    internal_quiet_a: assert property
        (((primary_core_irq_o | secondary_core_irq_o) & ~pmask) == '0)
        else $error("internal line driven");
    route_drive_a: assert property
        (src_irq_i[0] && pmask[route_p_r[0]] &&
         route_p_r[0] != `DCIR_NMI_LINE
         |=> primary_core_irq_o[$past(route_p_r[0])])
        else $error("routed source did not reach its line");
    drop_all_a: assert property
        ((&intl_s) |=> secondary_core_irq_o == '0)
        else $error("disconnected sources still drive secondary");
    shared_or_a: assert property
        (route_p_r[53] == route_p_r[54] && src_irq_i[54] &&
         pmask[route_p_r[54]] && route_p_r[54] != `DCIR_NMI_LINE
         |=> primary_core_irq_o[$past(route_p_r[54])])
        else $error("shared line missed one of its sources");
    nmi_block_a: assert property (primary_nmi_mask_i
        |=> !primary_core_irq_o[`DCIR_NMI_LINE])
        else $error("nmi line passed while masked");
    level_map_a: assert property
        (##1 level_r[53] == $past(src_irq_i[53]) &&
         level_r[64] == $past(src_irq_i[64]))
        else $error("source level not tracked");
    route_keep_a: assert property (wr_pri |=> $stable(route_s_r[0]))
        else $error("primary write disturbed secondary route");
    route_write_a: assert property (wr_pri && req.idx == 7'h00
        |=> route_p_r[0] == $past(wb_dat_i[4:0]))
        else $error("route field not written");

    ////////////////////////////////////////////////////////////////////
    // further checks: second core, nmi mask, flags, bus answer, routes and level words

    // source 55 sitting on the nmi line of a core, mask up or down
    sequence nmi_open_p_s;
        src_irq_i[55] && route_p_r[55] == `DCIR_NMI_LINE &&
        !primary_nmi_mask_i;
    endsequence
    sequence nmi_shut_p_s;
        src_irq_i[55] && route_p_r[55] == `DCIR_NMI_LINE &&
        primary_nmi_mask_i;
    endsequence
    sequence nmi_shut_s_s;
        src_irq_i[55] && route_s_r[55] == `DCIR_NMI_LINE &&
        secondary_nmi_mask_i;
    endsequence
    // a write that arrives without its low byte lane
    sequence lane_off_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0];
    endsequence
    // reads of the level words, answered one cycle after the take
    sequence lvl1_read_s;
        take && is_misc && !req.we && req.idx == `DCIR_IDX_LVL1;
    endsequence
    sequence lvl2_read_s;
        take && is_misc && !req.we && req.idx == `DCIR_IDX_LVL2;
    endsequence

    // the second core gets its own routed copy of a source
    route_drive_s_a: assert property
        (src_irq_i[53] && pmask[route_s_r[53]] &&
         route_s_r[53] != `DCIR_NMI_LINE
         |=> secondary_core_irq_o[$past(route_s_r[53])])
        else $error("routed source did not reach secondary line");

    // with every primary route internal the primary lines stay low
    drop_prim_a: assert property
        ((&intl_p) |=> primary_core_irq_o == '0)
        else $error("disconnected sources still drive primary");

    // the mask removes line 14 only while it is up
    nmi_pass_a: assert property
        (nmi_open_p_s |=> primary_core_irq_o[`DCIR_NMI_LINE])
        else $error("unmasked nmi source missed line 14");

    nmi_block_s_a: assert property (secondary_nmi_mask_i
        |=> !secondary_core_irq_o[`DCIR_NMI_LINE])
        else $error("secondary nmi line passed while masked");

    // a blocked nmi source leaves a flag behind for software
    evt_set_p_a: assert property (nmi_shut_p_s |=> evt_r[0])
        else $error("blocked primary nmi not flagged");

    evt_set_s_a: assert property (nmi_shut_s_s |=> evt_r[1])
        else $error("blocked secondary nmi not flagged");

    // flags are sticky: only a written one removes them
    evt_hold_a: assert property
        (evt_r[0] && !(wr_clr && wb_dat_i[0]) |=> evt_r[0])
        else $error("event flag lost without a clear");

    evt_clear_a: assert property
        (wr_clr && wb_dat_i[0] && !evt_set[0] |=> !evt_r[0])
        else $error("event flag not cleared");

    // enable writes land as written, low bits only
    evt_enable_a: assert property
        (wr_en |=> evt_en_r == $past(wb_dat_i[`DCIR_EVT_W-1:0]))
        else $error("event enable not written");

    // the interrupt follows the flags at once, an enable a cycle late
    irq_follow_a: assert property
        (1'b1 |=> irq_o == |(evt_r & $past(evt_en_r)))
        else $error("interrupt out of step with flags");

    // ack is a single pulse and data is zero outside it
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    rdat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data shown without ack");

    // a refused place reads zero: unmapped region or index past the end
    refused_read_a: assert property
        (take && !req.we &&
         ((req.rgn > `DCIR_RGN_MISC) || (!idx_ok && !is_misc))
         |=> wb_dat_o == '0)
        else $error("refused place returned data");

    // a write without its low byte lane leaves the route alone
    lane_drop_a: assert property
        (lane_off_s |=> $stable(route_p_r[53]))
        else $error("route written without its byte lane");

    // routes move only on a write to their own field
    route_hold_p_a: assert property
        (!wr_pri |=> $stable(route_p_r[0]))
        else $error("primary route changed without a write");

    route_hold_s_a: assert property
        (!wr_sec |=> $stable(route_s_r[0]))
        else $error("secondary route changed without a write");

    route_keep_s_a: assert property
        (wr_sec |=> $stable(route_p_r[0]))
        else $error("secondary write disturbed primary route");

    route_write_s_a: assert property (wr_sec && req.idx == 7'h00
        |=> route_s_r[0] == $past(wb_dat_i[4:0]))
        else $error("secondary route field not written");

    // status words: source 53 at bit 21 of word 1, 64 at bit 0 of word 2
    level_word1_a: assert property
        (lvl1_read_s |=> wb_dat_o[21] == $past(level_r[53]))
        else $error("source 53 not at bit 21 of word 1");

    level_word2_a: assert property
        (lvl2_read_s |=> wb_dat_o[0] == $past(level_r[64]))
        else $error("source 64 not at bit 0 of word 2");

    level_edge_a: assert property
        (1'b1 |=> level_r[68] == $past(src_irq_i[68]))
        else $error("last source level not tracked");

endmodule
`default_nettype wire

// ===== bench/dcir_core_model.sv
// behavioural model of one core's interrupt inputs
`timescale 1ns/1ns
`default_nettype none
module dcir_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] line_i,
    output logic      [2:0]  level_o
);
    logic [31:0] prev_r;
    logic [31:0] edge_r;
    // fixed level per peripheral line, internal lines never reach here
    function automatic logic [2:0] pri(input int n);
        if (n inside {19, 20, 21}) return 3'h2;
        if (n inside {22, 23, 27}) return 3'h3;
        if (n inside {24, 25, 28, 30}) return 3'h4;
        if (n inside {26, 31}) return 3'h5;
        return 3'h1;
    endfunction
    // edge lines latch a rise; sticky because no core handler clears it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r <= 32'h0;
            edge_r <= 32'h0;
        end else begin
            prev_r <= line_i;
            edge_r <= edge_r | (line_i & ~prev_r & 32'h5040_0400);
        end
    end
    // highest pending level; line 14 is the nmi and skips the ladder
    always_comb begin
        level_o = 3'h0;
        for (int n = 0; n < 32; n++) begin
            if (n != 14 && (edge_r[n] || (line_i[n] &&
                !(n inside {10, 22, 28, 30}))) && pri(n) > level_o)
                level_o = pri(n);
        end
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the dual core interrupt router
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        pmask = 1'b0;
    logic        smask = 1'b0;
    logic        ack, irq;
    logic [3:0]  sel = 4'hf;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd, rdat, pcore, score;
    logic [68:0] src = 69'h0;
    logic [2:0]  plvl;
    int          err_total = 0;
    int          total_checks = 0;
    // source, primary line, secondary line; covers every internal value
    int rows [8][3] = '{'{53, 0, 31}, '{54, 5, 6}, '{68, 10, 29},
        '{60, 17, 28}, '{64, 30, 11}, '{0, 22, 14}, '{40, 7, 15},
        '{65, 16, 3}};
    always #10 sys_clk_i = ~sys_clk_i;
    dcir_router DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .src_irq_i(src), .primary_nmi_mask_i(pmask),
        .secondary_nmi_mask_i(smask), .primary_core_irq_o(pcore),
        .secondary_core_irq_o(score), .irq_o(irq));
    dcir_core_model core_a (.clk_i(sys_clk_i), .rst_i(sys_rst_i),
        .line_i(pcore), .level_o(plvl));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // classic cycle: hold until ack is seen, only then release
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no cycle count assumed: only the watchdog ends a lost answer
        do begin
            @(posedge sys_clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        sel <= 4'hf;
    endtask
    function automatic logic [31:0] ln(input int l);
        return (l inside {6, 7, 11, 15, 16, 29}) ? 32'h0 : 32'h1 << l;
    endfunction
    task automatic test_done;
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(3);
        sys_rst_i <= 1'b0;
        chk("pcore rst", pcore, 32'h0);
        wb(1'b0, 12'h0d4, 32'h0);
        chk("route rst", rd, 32'h6);
        foreach (rows[i]) begin
            wb(1'b1, 12'(4 * rows[i][0]), 32'(rows[i][1]));
            wb(1'b1, 12'h200 + 12'(4 * rows[i][0]), 32'(rows[i][2]));
            src[rows[i][0]] <= 1'b1;
            tick(2);
            chk("pcore", pcore, ln(rows[i][1]));
            chk("score", score, ln(rows[i][2]));
            wb(1'b0, 12'h400 + 12'(4 * (rows[i][0] / 32)), 32'h0);
            chk("level", rd, 32'h1 << (rows[i][0] % 32));
            src[rows[i][0]] <= 1'b0;
            wb(1'b1, 12'(4 * rows[i][0]), 32'h6);
            wb(1'b1, 12'h200 + 12'(4 * rows[i][0]), 32'h6);
        end
        // field width, then a write without its low byte lane is dropped
        wb(1'b1, 12'h0d4, 32'hffff_ffff);
        sel <= 4'he;
        wb(1'b1, 12'h0d4, 32'h6);
        wb(1'b0, 12'h0d4, 32'h0);
        chk("route w", rd, 32'h1f);
        // two sources share one line; either keeps it high
        wb(1'b1, 12'h0d4, 32'h13);
        wb(1'b1, 12'h0d8, 32'h13);
        src[53] <= 1'b1;
        tick(2);
        chk("or one", pcore, 32'h0008_0000);
        src[54] <= 1'b1;
        src[53] <= 1'b0;
        tick(2);
        chk("or two", pcore, 32'h0008_0000);
        src[54] <= 1'b0;
        // nmi routing with per-core mask and the block event
        wb(1'b1, 12'h0dc, 32'he);
        wb(1'b1, 12'h2dc, 32'he);
        wb(1'b1, 12'h418, 32'h3);
        pmask <= 1'b1;
        src[55] <= 1'b1;
        tick(2);
        chk("nmi p", pcore, 32'h0);
        chk("nmi s", score, 32'h4000);
        smask <= 1'b1;
        tick(2);
        chk("nmi s2", score, 32'h0);
        wb(1'b0, 12'h410, 32'h0);
        chk("evt", rd, 32'h3);
        chk("irq", {31'h0, irq}, 32'h1);
        pmask <= 1'b0;
        smask <= 1'b0;
        wb(1'b1, 12'h418, 32'h0);
        tick(2);
        chk("irq off", {31'h0, irq}, 32'h0);
        wb(1'b1, 12'h418, 32'h3);
        wb(1'b1, 12'h414, 32'h3);
        tick(2);
        chk("irq clr", {31'h0, irq}, 32'h0);
        // unmapped place and a route index past the last source
        wb(1'b0, 12'h800, 32'h0);
        chk("unmap", rd, 32'h0);
        wb(1'b0, 12'h114, 32'h0);
        chk("idx69", rd, 32'h0);
        // reset in mid-run: routes, flags, outputs and the model go back
        src[55] <= 1'b0;
        sys_rst_i <= 1'b1;
        tick(3);
        sys_rst_i <= 1'b0;
        chk("pcore rst2", pcore, 32'h0);
        chk("score rst2", score, 32'h0);
        chk("irq rst2", {31'h0, irq}, 32'h0);
        chk("plvl rst2", {29'h0, plvl}, 32'h0);
        wb(1'b0, 12'h2dc, 32'h0);
        chk("route rst2", rd, 32'h6);
        wb(1'b0, 12'h410, 32'h0);
        chk("evt rst2", rd, 32'h0);
        // the core model sees a level line, then an edge line latched
        wb(1'b1, 12'h0d4, 32'h1a);
        src[53] <= 1'b1;
        tick(2);
        chk("lvl five", {29'h0, plvl}, 32'h5);
        src[53] <= 1'b0;
        tick(2);
        chk("lvl off", {29'h0, plvl}, 32'h0);
        wb(1'b1, 12'h0d4, 32'h16);
        src[53] <= 1'b1;
        tick(1);
        src[53] <= 1'b0;
        tick(3);
        chk("lvl edge", {29'h0, plvl}, 32'h3);
        test_done;
    end
    initial begin
        tick(3000);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
